// [rtl/process_load_stall_monitor.sv]
`timescale 1ns/100ps
`include "monitor_cfg.svh"

module process_load_stall_monitor #(
   parameter int unsigned TICK_CYCLES =
      `TICK_PERIOD_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire monitor_pkg::meas_type meas,
   input wire monitor_pkg::settings_type cfg,
   input wire logic fault_clear,
   output monitor_pkg::status_type status,
   output monitor_pkg::stop_type stop,
   output logic ul_restart_ok,
   output logic ol_restart_ok,
   output logic [6:0] ul_limit
);
   import monitor_pkg::*;

   localparam logic [24:0] TICK_LAST = 25'(TICK_CYCLES - 1);

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // clamp a 13-bit frequency into a range
   function automatic logic [12:0] clamp13(input logic [12:0] v,
                                           input logic [12:0] lo,
                                           input logic [12:0] hi);
      logic [12:0] r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   // clamp a 7-bit setting to an upper bound
   function automatic logic [6:0] cap7(input logic [6:0] v,
                                       input logic [6:0] hi);
      return (v > hi) ? hi : v;
   endfunction

   // torque limit between zero and rated frequency, square law
   function automatic logic [6:0] ul_curve(input logic [6:0] zero,
                                           input logic [6:0] nom,
                                           input logic [12:0] f,
                                           input logic [12:0] fr);
      logic [12:0] fc;
      logic [32:0] num;
      logic [25:0] den;
      logic [32:0] q;
      fc = (f > fr) ? fr : f;
      num = 33'(nom - zero) * 33'(fc) * 33'(fc);
      den = 26'(fr) * 26'(fr);
      if (den == 26'h000_0000) begin
         q = 33'(nom - zero);
      end else begin
         q = num / 33'(den);
      end
      return zero + q[6:0];
   endfunction

   // absolute difference of two frequencies
   function automatic logic [12:0] fdiff(input logic [12:0] a,
                                         input logic [12:0] b);
      return (a > b) ? (a - b) : (b - a);
   endfunction

   // ****************************************************************
   // settings held within their ranges
   // ****************************************************************
   logic [6:0] ul_dly;
   logic [6:0] ul_nom;
   logic [6:0] ul_zero;
   logic [12:0] ul_minf;
   logic [12:0] hyst;
   logic [12:0] rated_f;
   logic [6:0] ol_dly;
   logic [7:0] ol_thr;
   logic [2:0] ul_lock;
   logic [2:0] ol_lock;
   logic [11:0] st_time;
   logic [10:0] st_cur;
   logic [12:0] st_freq;

   // out-of-range writes are pulled to the nearest legal value, except the stall current factory value
   always_comb begin
      ul_dly = cap7(cfg.ul_delay_s, `DLY_MAX);
      ul_nom = cap7(cfg.ul_thr_nom, `UL_NOM_MAX);
      if (ul_nom < `UL_NOM_MIN) begin
         ul_nom = `UL_NOM_MIN;
      end
      ul_zero = cap7(cfg.ul_thr_zero, ul_nom);
      ul_minf = clamp13(cfg.ul_min_freq, 13'h0000, `FREQ_MAX);
      hyst = clamp13(cfg.hyst_freq, `HYST_MIN, `FREQ_MAX);
      rated_f = clamp13(cfg.rated_freq, 13'h0000, `FREQ_MAX);
      ol_dly = cap7(cfg.ol_delay_s, `DLY_MAX);
      ol_thr = cfg.ol_thr_pct;
      if (ol_thr < `OL_THR_MIN) begin
         ol_thr = `OL_THR_MIN;
      end else if (ol_thr > `OL_THR_MAX) begin
         ol_thr = `OL_THR_MAX;
      end
      ul_lock = (cfg.ul_lock_min > `LOCK_MAX) ? `LOCK_MAX
                                              : cfg.ul_lock_min;
      ol_lock = (cfg.ol_lock_min > `LOCK_MAX) ? `LOCK_MAX
                                              : cfg.ol_lock_min;
      st_time = (cfg.stall_time > `STALL_T_MAX) ? `STALL_T_MAX
                                                : cfg.stall_time;
      // the factory value sits above the settable range, keep it
      st_cur = cfg.stall_cur;
      if (st_cur > `STALL_I_MAX && st_cur != `STALL_I_DEF) begin
         st_cur = `STALL_I_MAX;
      end
      st_freq = clamp13(cfg.stall_freq, 13'h0000, `FREQ_MAX);
   end

   // ****************************************************************
   // time base: 0.1 s and 1 min ticks
   // ****************************************************************
   logic [24:0] pre_q;
   logic [24:0] pre_d;
   logic [9:0] min_q;
   logic [9:0] min_d;
   logic tick_q;
   logic tick_d;
   logic mtick_q;
   logic mtick_d;

   // one prescaler feeds every timer so they all share one grid
   always_comb begin
      tick_d = (pre_q == TICK_LAST);
      pre_d = tick_d ? 25'h000_0000 : pre_q + 25'h000_0001;
      mtick_d = 1'b0;
      min_d = min_q;
      if (tick_q) begin
         if (min_q == `TICKS_PER_MIN - 10'h001) begin
            min_d = 10'h000;
            mtick_d = 1'b1;
         end else begin
            min_d = min_q + 10'h001;
         end
      end
   end

   // registers
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pre_q <= 25'h000_0000;
         min_q <= 10'h000;
         tick_q <= 1'b0;
         mtick_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         min_q <= min_d;
         tick_q <= tick_d;
         mtick_q <= mtick_d;
      end
   end

   // ****************************************************************
   // qualifying conditions
   // ****************************************************************
   logic [6:0] limit_q;
   logic [6:0] limit_d;
   logic steady;
   logic ul_cond;
   logic ol_cond;
   logic st_cond;
   logic [11:0] ul_ticks;
   logic [11:0] ol_ticks;

   // the divide is registered so it stays off the compare path
   always_comb begin
      limit_d = ul_curve(ul_zero, ul_nom, meas.freq, rated_f);
      steady = fdiff(meas.freq_ref, meas.freq) < hyst;
      ul_cond = steady && (meas.torque_pct < {1'b0, limit_q}) &&
                (meas.freq >= ul_minf);
      // current limitation alone qualifies, ramping or not
      ol_cond = (meas.cur_limit && meas.ramping) ||
                meas.cur_limit ||
                (steady && (meas.current_pmil >
                 11'(ol_thr) * `TENTHS_PER_PCT));
      st_cond = (meas.freq < st_freq) &&
                (meas.current_pmil > st_cur);
      ul_ticks = 12'(ul_dly) * `TICKS_PER_S;
      ol_ticks = 12'(ol_dly) * `TICKS_PER_S;
   end

   // registers
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         limit_q <= 7'h00;
      end else begin
         limit_q <= limit_d;
      end
   end

   // ****************************************************************
   // persistence timers
   // ****************************************************************
   logic ul_det;
   logic ol_det;
   logic st_det;

   // underload: at least the delay, zero delay disables
   persist_timer ul_timer (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .enable(ul_dly != 7'h00),
      .cond(ul_cond),
      .tick(tick_q),
      .limit(ul_ticks),
      .strict(1'b0),
      .expired(ul_det)
   );

   // overload: same form as underload
   persist_timer ol_timer (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .enable(ol_dly != 7'h00),
      .cond(ol_cond),
      .tick(tick_q),
      .limit(ol_ticks),
      .strict(1'b0),
      .expired(ol_det)
   );

   // stall: strictly longer than the stall time
   persist_timer st_timer (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .enable(cfg.stall_en),
      .cond(st_cond),
      .tick(tick_q),
      .limit(st_time),
      .strict(1'b1),
      .expired(st_det)
   );

   // ****************************************************************
   // reactions
   // ****************************************************************
   logic ul_err;
   logic ol_err;
   logic st_err;
   stop_type ul_stop;
   stop_type ol_stop;
   stop_type st_stop;

   // underload reaction and lockout
   reaction_unit ul_react (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .detect(ul_det),
      .reaction(cfg.ul_react),
      .lock_min(ul_lock),
      .reset_time_min(cfg.reset_time_min),
      .min_tick(mtick_q),
      .fault_clear(fault_clear),
      .error(ul_err),
      .stop(ul_stop),
      .restart_ok(ul_restart_ok)
   );

   // overload reaction and lockout
   reaction_unit ol_react (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .detect(ol_det),
      .reaction(cfg.ol_react),
      .lock_min(ol_lock),
      .reset_time_min(cfg.reset_time_min),
      .min_tick(mtick_q),
      .fault_clear(fault_clear),
      .error(ol_err),
      .stop(ol_stop),
      .restart_ok(ol_restart_ok)
   );

   // stall always trips with a freewheel stop and no lockout
   reaction_unit st_react (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .detect(st_det),
      .reaction(react_freewheel),
      .lock_min(3'h0),
      .reset_time_min(cfg.reset_time_min),
      .min_tick(mtick_q),
      .fault_clear(fault_clear),
      .error(st_err),
      .stop(st_stop),
      .restart_ok()
   );

   // ****************************************************************
   // outputs
   // ****************************************************************
   // all sources are flops; the merge is a plain or
   assign status.ul_err = ul_err;
   assign status.ol_err = ol_err;
   assign status.stall_err = st_err;
   assign status.ul_relay = ul_err;
   assign stop = ul_stop | ol_stop | st_stop;
   assign ul_limit = limit_q;
endmodule

// [rtl/monitor_cfg.svh]
`ifndef MONITOR_CFG_SVH
`define MONITOR_CFG_SVH

// ****************************************************************
// timing base
// ****************************************************************
`define CLK_PERIOD_NS 4
`define TICK_PERIOD_MS 100
`define NS_PER_MS 1_000_000
`define TICKS_PER_S 12'h00a
`define TICKS_PER_MIN 10'h258

// ****************************************************************
// frequency settings, 0.1 Hz units
// ****************************************************************
`define FREQ_MAX 13'h1766
`define HYST_MIN 13'h0003
`define HYST_DEF 13'h0003
`define MINF_DEF 13'h0000
`define RATED_F_DEF 13'h01f4
`define STALL_F_DEF 13'h0014

// ****************************************************************
// underload and overload settings
// ****************************************************************
`define DLY_MAX 7'h64
`define DLY_DEF 7'h00
`define UL_NOM_MIN 7'h14
`define UL_NOM_MAX 7'h64
`define UL_NOM_DEF 7'h3c
`define UL_ZERO_DEF 7'h00
`define OL_THR_MIN 8'h46
`define OL_THR_MAX 8'h96
`define OL_THR_DEF 8'h6e
`define LOCK_MAX 3'h6
`define LOCK_DEF 3'h0
`define LOCK_MARGIN 8'h01
`define RESET_TIME_DEF 8'h00

// ****************************************************************
// stall settings, 0.1 s and 0.1 % units
// ****************************************************************
`define STALL_T_MAX 12'h7d0
`define STALL_T_DEF 12'h258
`define STALL_I_MAX 11'h4b0
`define STALL_I_DEF 11'h5dc
`define TENTHS_PER_PCT 11'h00a

`endif

// [rtl/monitor_pkg.sv]
`include "monitor_cfg.svh"

package monitor_pkg;

   // stop reaction selection
   typedef enum logic [1:0] {
      react_ignore = 2'h0,
      react_freewheel = 2'h1,
      react_ramp = 2'h2,
      react_fast = 2'h3
   } reaction_type;

   // quantities from the motor-control core
   typedef struct packed {
      logic [7:0] torque_pct;
      logic [10:0] current_pmil;
      logic [12:0] freq;
      logic [12:0] freq_ref;
      logic cur_limit;
      logic ramping;
   } meas_type;

   // configuration settings
   typedef struct packed {
      logic [6:0] ul_delay_s;
      logic [6:0] ul_thr_nom;
      logic [6:0] ul_thr_zero;
      logic [12:0] ul_min_freq;
      logic [12:0] hyst_freq;
      logic [12:0] rated_freq;
      reaction_type ul_react;
      logic [2:0] ul_lock_min;
      logic [6:0] ol_delay_s;
      logic [7:0] ol_thr_pct;
      reaction_type ol_react;
      logic [2:0] ol_lock_min;
      logic [7:0] reset_time_min;
      logic stall_en;
      logic [11:0] stall_time;
      logic [10:0] stall_cur;
      logic [12:0] stall_freq;
   } settings_type;

   // stop commands towards the core
   typedef struct packed {
      logic freewheel;
      logic ramp;
      logic fast;
   } stop_type;

   // error indications
   typedef struct packed {
      logic ul_err;
      logic ol_err;
      logic stall_err;
      logic ul_relay;
   } status_type;

   // factory settings
   localparam settings_type settings_default = '{
      ul_delay_s: `DLY_DEF, ul_thr_nom: `UL_NOM_DEF,
      ul_thr_zero: `UL_ZERO_DEF, ul_min_freq: `MINF_DEF,
      hyst_freq: `HYST_DEF, rated_freq: `RATED_F_DEF,
      ul_react: react_freewheel, ul_lock_min: `LOCK_DEF,
      ol_delay_s: `DLY_DEF, ol_thr_pct: `OL_THR_DEF,
      ol_react: react_freewheel, ol_lock_min: `LOCK_DEF,
      reset_time_min: `RESET_TIME_DEF, stall_en: 1'b0,
      stall_time: `STALL_T_DEF, stall_cur: `STALL_I_DEF,
      stall_freq: `STALL_F_DEF
   };

endpackage

// [rtl/persist_timer.sv]
`timescale 1ns/100ps

module persist_timer (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic cond,
   input wire logic tick,
   input wire logic [11:0] limit,
   input wire logic strict,
   output logic expired
);
   logic [11:0] cnt_q;
   logic [11:0] cnt_d;
   logic expired_q;
   logic expired_d;
   logic run;

   // ****************************************************************
   // persistence count in 0.1 s ticks
   // ****************************************************************
   // count restarts from zero as soon as the condition lapses
   always_comb begin
      run = enable & cond;
      cnt_d = cnt_q;
      if (!run) begin
         cnt_d = 12'h000;
      end else if (tick && cnt_q != 12'hfff) begin
         cnt_d = cnt_q + 12'h001;
      end
      if (strict) begin
         expired_d = run && (cnt_q > limit);
      end else begin
         expired_d = run && (cnt_q >= limit);
      end
   end

   // registers
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cnt_q <= 12'h000;
         expired_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         expired_q <= expired_d;
      end
   end

   assign expired = expired_q;
endmodule

// [rtl/reaction_unit.sv]
`timescale 1ns/100ps
`include "monitor_cfg.svh"

module reaction_unit (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic detect,
   input wire monitor_pkg::reaction_type reaction,
   input wire logic [2:0] lock_min,
   input wire logic [7:0] reset_time_min,
   input wire logic min_tick,
   input wire logic fault_clear,
   output logic error,
   output monitor_pkg::stop_type stop,
   output logic restart_ok
);
   import monitor_pkg::*;

   logic err_q;
   logic err_d;
   stop_type stop_q;
   stop_type stop_d;
   logic [2:0] lock_q;
   logic [2:0] lock_d;
   logic ok_q;
   logic ok_d;
   logic trip;

   // ****************************************************************
   // error latch, stop command and restart lockout
   // ****************************************************************
   // a trip in the clear cycle keeps the error, so none is lost
   always_comb begin
      trip = detect && (reaction != react_ignore);
      err_d = trip | (err_q & ~fault_clear);
      stop_d = stop_q;
      if (trip) begin
         stop_d.freewheel = (reaction == react_freewheel);
         stop_d.ramp = (reaction == react_ramp);
         stop_d.fast = (reaction == react_fast);
      end else if (fault_clear) begin
         stop_d = '0;
      end
      lock_d = lock_q;
      if (trip) begin
         lock_d = lock_min;
      end else if (min_tick && lock_q != 3'h0) begin
         lock_d = lock_q - 3'h1;
      end
      // restart needs the reset time a full minute past the lockout
      ok_d = (lock_q == 3'h0) &&
             ((lock_min == 3'h0) ||
              (reset_time_min >= ({5'h00, lock_min} + `LOCK_MARGIN)));
   end

   // registers
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         err_q <= 1'b0;
         stop_q <= '0;
         lock_q <= 3'h0;
         ok_q <= 1'b0;
      end else begin
         err_q <= err_d;
         stop_q <= stop_d;
         lock_q <= lock_d;
         ok_q <= ok_d;
      end
   end

   assign error = err_q;
   assign stop = stop_q;
   assign restart_ok = ok_q;
endmodule

// [verification/process_load_stall_monitor_properties.sv]
`timescale 1ns/100ps
// ************
// monitor port checks
// ************
module process_load_stall_monitor_properties #(
   parameter int unsigned TICK_CYCLES = 10
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire monitor_pkg::meas_type meas,
   input wire monitor_pkg::settings_type cfg,
   input wire logic fault_clear,
   input wire monitor_pkg::status_type status,
   input wire monitor_pkg::stop_type stop,
   input wire logic ul_restart_ok,
   input wire logic ol_restart_ok,
   input wire logic [6:0] ul_limit
);
   import monitor_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // a zero delay, or stall_en low for stall, must keep a monitor silent
   a_ol_needs_delay: assert property (
      $rose(status.ol_err) |-> $past(cfg.ol_delay_s) != 7'h00)
      else $error("overload error with zero delay");
   a_ul_needs_delay: assert property (
      $rose(status.ul_err) |-> $past(cfg.ul_delay_s) != 7'h00)
      else $error("underload error with zero delay");
   a_stall_needs_en: assert property (
      $rose(status.stall_err) |-> $past(cfg.stall_en))
      else $error("stall error while disabled");
   a_ul_relay_set: assert property (
      $rose(status.ul_err) |-> ##[0:1] status.ul_relay)
      else $error("relay missed underload");
   a_ol_err_held: assert property (
      status.ol_err && !fault_clear |=> status.ol_err)
      else $error("overload error dropped without clear");
   a_ol_ignore_quiet: assert property (
      $rose(status.ol_err) |-> cfg.ol_react != react_ignore)
      else $error("ignored overload raised error");
   a_ol_ramp_stop: assert property (
      $rose(status.ol_err) && cfg.ol_react == react_ramp |-> stop.ramp)
      else $error("ramp stop missing");
   a_stall_coasts: assert property (
      $rose(status.stall_err) |-> stop.freewheel)
      else $error("stall without freewheel stop");
   a_ul_min_freq: assert property (
      $rose(status.ul_err) |->
      $past(meas.freq, 2) >= $past(cfg.ul_min_freq, 2))
      else $error("underload below minimum frequency");
   a_ol_lockout: assert property (
      $rose(status.ol_err) && cfg.ol_lock_min != 3'h0
      |-> ##2 !ol_restart_ok)
      else $error("restart allowed during lockout");
   // restart needs the reset time one minute past the lockout
   a_ul_reset_margin: assert property (
      cfg.ul_lock_min != 3'h0 &&
      {5'h00, cfg.ul_lock_min} >= cfg.reset_time_min |=> !ul_restart_ok)
      else $error("restart allowed with short reset time");
   c_ol_trip: cover property ($rose(status.ol_err));
   c_ul_trip: cover property ($rose(status.ul_err));
   c_stall_trip: cover property ($rose(status.stall_err));
endmodule

bind process_load_stall_monitor process_load_stall_monitor_properties #(
   .TICK_CYCLES(TICK_CYCLES)
) u_props (
   .ref_clk(ref_clk), .rst_b(rst_b), .meas(meas), .cfg(cfg),
   .fault_clear(fault_clear), .status(status), .stop(stop),
   .ul_restart_ok(ul_restart_ok), .ol_restart_ok(ol_restart_ok),
   .ul_limit(ul_limit)
);

// [verification/motor_core_model.sv]
`timescale 1ns/100ps
// ************
// motor-control core stand-in
// ************
module motor_core_model #(
   parameter int STEP = 64
) (
   input wire logic ref_clk,
   input wire monitor_pkg::stop_type stop,
   input wire logic [7:0] torque,
   input wire logic [10:0] current,
   input wire logic [12:0] speed_set,
   input wire logic [12:0] slip,
   input wire logic in_limit,
   output monitor_pkg::meas_type meas
);
   import monitor_pkg::*;
   int f = 0;
   int goal;
   // any stop drops the reference; the shaft slews, so steady lags
   always_comb goal = (|stop) ? 0 : int'(speed_set) - int'(slip);
   always @(posedge ref_clk) begin
      if (f < goal - STEP) f <= f + STEP;
      else if (f > goal + STEP) f <= f - STEP;
      else f <= goal;
   end
   always_comb begin
      meas.torque_pct = torque;
      meas.current_pmil = current;
      meas.freq = 13'(f);
      meas.freq_ref = (|stop) ? 13'h0000 : speed_set;
      meas.cur_limit = in_limit;
      meas.ramping = (f != goal);
   end
endmodule

// [verification/tb_process_load_stall_monitor.sv]
`timescale 1ns/100ps
// ************
// monitor bench
// ************
module tb_process_load_stall_monitor;
   import monitor_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic fault_clear = 1'b0;
   settings_type cfg = settings_default;
   meas_type meas;
   status_type status;
   stop_type stop;
   logic ul_ok, ol_ok;
   logic [6:0] ul_limit;
   logic [7:0] torque = 8'h64;
   logic [10:0] current = 11'h000;
   logic [12:0] spd = 13'h0000;
   logic [12:0] slip = 13'h0000;
   logic lim = 1'b0;
   logic [15:0] seed = 16'h0028;
   int num_errors = 0;
   int n_checks = 0;
   int nom, zer, f;
   // stop bits per reaction code: freewheel, ramp, fast
   logic [2:0] stop_tab [4] = '{3'h0, 3'h4, 3'h2, 3'h1};

   always #2 ref_clk = ~ref_clk;

   process_load_stall_monitor #(.TICK_CYCLES(10)) DUT (
      .ref_clk(ref_clk), .rst_b(rst_b), .meas(meas), .cfg(cfg),
      .fault_clear(fault_clear), .status(status), .stop(stop),
      .ul_restart_ok(ul_ok), .ol_restart_ok(ol_ok), .ul_limit(ul_limit)
   );
   motor_core_model #(.STEP(64)) u_core (
      .ref_clk(ref_clk), .stop(stop), .torque(torque), .current(current),
      .speed_set(spd), .slip(slip), .in_limit(lim), .meas(meas)
   );

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // square-law limit, frequency clamped at rated, truncating
   function automatic int exp_limit(input int n, z, fr);
      int r;
      int q;
      r = int'(settings_default.rated_freq);
      q = fr > r ? r : fr;
      return z + (n - z) * q * q / (r * r);
   endfunction
   function automatic logic flag(input int k);
      return k == 0 ? status.ul_err :
         k == 1 ? status.ol_err : status.stall_err;
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // let the cause lapse first, or a standing detect sets it again
   task automatic clear();
      cyc(2);
      fault_clear <= 1'b1;
      cyc(1);
      fault_clear <= 1'b0;
      cyc(3);
   endtask
   // one second of cause: quiet at 88 cycles, settled by 128
   task automatic expect_trip(input int k, input logic hit);
      cyc(88);
      chk("early flag", flag(k), 1'b0);
      cyc(40);
      chk("trip flag", flag(k), hit);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      cyc(30000);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      cyc(12);
      rst_b <= 1'b1;
      cyc(3);
      chk("status", status, 4'h0);
      chk("ul ok", ul_ok, 1'b1);
      $display("test reset done");
      cfg.ul_delay_s <= 7'h01;
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         nom = 20 + int'(seed) % 81;
         seed = lfsr(seed);
         zer = int'(seed) % (nom + 1);
         seed = lfsr(seed);
         f = int'(seed) % 1000;
         cfg.ul_thr_nom <= 7'(nom);
         cfg.ul_thr_zero <= 7'(zer);
         spd <= 13'(f);
         cyc(20);
         chk("limit", ul_limit, exp_limit(nom, zer, f));
      end
      $display("test limit done");
      cfg.ul_delay_s <= 7'h00;
      cfg.ol_delay_s <= 7'h01;
      spd <= 13'h01f4;
      for (int r = 0; r < 4; r++) begin
         cfg.ol_react <= reaction_type'(r);
         lim <= 1'b1;
         expect_trip(1, r != 0);
         chk("ol stop", stop, stop_tab[r]);
         lim <= 1'b0;
         clear();
         chk("ol clear", status.ol_err, 1'b0);
      end
      $display("test reactions done");
      cfg.ol_react <= react_freewheel;
      lim <= 1'b1;
      cyc(60);
      lim <= 1'b0;
      cyc(20);
      lim <= 1'b1;
      expect_trip(1, 1'b1);
      lim <= 1'b0;
      clear();
      $display("test restart timer done");
      current <= 11'h3e8;
      expect_trip(1, 1'b0);
      cfg.ol_lock_min <= 3'h2;
      cfg.reset_time_min <= 8'h02;
      current <= 11'h4b0;
      expect_trip(1, 1'b1);
      current <= 11'h000;
      clear();
      chk("ol ok short", ol_ok, 1'b0);
      cfg.reset_time_min <= 8'h03;
      cyc(3);
      chk("ol ok locked", ol_ok, 1'b0);
      cyc(12100);
      chk("ol ok free", ol_ok, 1'b1);
      $display("test overcurrent done");
      cfg.ol_delay_s <= 7'h00;
      cfg.ul_delay_s <= 7'h01;
      cfg.ul_thr_nom <= 7'h3c;
      cfg.ul_thr_zero <= 7'h00;
      torque <= 8'h0a;
      slip <= 13'h000a;
      expect_trip(0, 1'b0);
      slip <= 13'h0000;
      cfg.ul_min_freq <= 13'h0258;
      cfg.ul_lock_min <= 3'h1;
      cfg.reset_time_min <= 8'h01;
      expect_trip(0, 1'b0);
      chk("ul ok short", ul_ok, 1'b0);
      cfg.ul_min_freq <= 13'h0000;
      expect_trip(0, 1'b1);
      chk("relay", status.ul_relay, 1'b1);
      chk("ul stop", stop, 3'h4);
      torque <= 8'h64;
      clear();
      $display("test underload done");
      cfg.ul_delay_s <= 7'h00;
      cfg.stall_en <= 1'b1;
      cfg.stall_time <= 12'h00a;
      cfg.stall_cur <= 11'h3e8;
      spd <= 13'h000a;
      current <= 11'h44c;
      expect_trip(2, 1'b1);
      chk("stall stop", stop, 3'h4);
      current <= 11'h000;
      clear();
      cfg.stall_en <= 1'b0;
      current <= 11'h44c;
      expect_trip(2, 1'b0);
      $display("test stall done");
      tally_and_finish();
   end
endmodule
